// file: common/mmd_pkg.sv
// Purpose: constants and types shared by the memory map decoder
// Assumes: 22-bit word addresses, 32-bit data words
// Notes: region bounds are inclusive start, exclusive end
package mmd_pkg;
   localparam int unsigned AW = 22;
   localparam int unsigned DW = 32;
   // ----------------------------------------------------------------
   // region bounds
   // ----------------------------------------------------------------
   localparam logic [21:0] LOWVEC_LO = 22'h000000;
   localparam logic [21:0] LOWVEC_HI = 22'h000040;
   localparam logic [21:0] LOWRAM_A_LO = 22'h000000;
   localparam logic [21:0] LOWRAM_B_LO = 22'h000400;
   localparam logic [21:0] LOWRAM_HI = 22'h000800;
   localparam logic [21:0] PF0_LO = 22'h000800;
   localparam logic [21:0] PF0_HI = 22'h002000;
   localparam logic [21:0] TIMER_LO = 22'h000c00;
   localparam logic [21:0] TIMER_HI = 22'h000c40;
   localparam logic [21:0] EXPVEC_LO = 22'h000d00;
   localparam logic [21:0] EXPVEC_HI = 22'h000e00;
   localparam logic [21:0] ACC2CPU_LO = 22'h001480;
   localparam logic [21:0] CPU2ACC_LO = 22'h001500;
   localparam logic [21:0] CPU2ACC_HI = 22'h001580;
   localparam logic [21:0] PF1A_LO = 22'h006000;
   localparam logic [21:0] PF3_LO = 22'h006400;
   localparam logic [21:0] PF1B_LO = 22'h006a00;
   localparam logic [21:0] PF2_LO = 22'h007000;
   localparam logic [21:0] PF2_HI = 22'h008000;
   localparam logic [21:0] SHR_A_LO = 22'h008000;
   localparam logic [21:0] SHR_B_LO = 22'h008800;
   localparam logic [21:0] SHR_C_LO = 22'h008c00;
   localparam logic [21:0] SHR_D_LO = 22'h009000;
   localparam logic [21:0] SHR_HI = 22'h00a000;
   localparam logic [21:0] ACCROM_LO = 22'h00f000;
   localparam logic [21:0] ACCROM_HI = 22'h010000;
   localparam logic [21:0] OTP_LO = 22'h3d7800;
   localparam logic [21:0] PWD_LO = 22'h3d7800;
   localparam logic [21:0] PWD_HI = 22'h3d7c00;
   localparam logic [21:0] CAL_LO = 22'h3d7e00;
   localparam logic [21:0] OTP_HI = 22'h3d7ff0;
   localparam logic [21:0] FLASH_LO = 22'h3e8000;
   localparam logic [21:0] FLASH_HI = 22'h3f8000;
   localparam logic [21:0] SROM_LO = 22'h3f8000;
   localparam logic [21:0] SROM_HI = 22'h3f8800;
   localparam logic [21:0] BROM_LO = 22'h3fd000;
   localparam logic [21:0] BOOTVEC_LO = 22'h3fffc0;
   localparam int unsigned FLASH_SECTORS = 10;
   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam logic [4:0] PF_READ_WAIT = 5'h02;
   localparam logic [4:0] PF1_WW_STALL = 5'h01;
   localparam logic [4:0] PWD_WAIT = 5'h10;
   localparam logic [4:0] OTP_MIN_WAIT = 5'h01;
   localparam logic [4:0] RAND_MIN_WAIT = 5'h01;
   localparam logic [4:0] PF_ORDER_WAIT = 5'h01;
   localparam logic PROT_RESET = 1'b1;

   typedef enum logic [4:0] {
      MMD_R_NONE = 5'h00, MMD_R_LOWVEC = 5'h01, MMD_R_RAM_A = 5'h02,
      MMD_R_RAM_B = 5'h03, MMD_R_PF0 = 5'h04, MMD_R_TIMER = 5'h05,
      MMD_R_EXPVEC = 5'h06, MMD_R_A2C = 5'h07, MMD_R_C2A = 5'h08,
      MMD_R_PF1 = 5'h09, MMD_R_PF2 = 5'h0a, MMD_R_PF3 = 5'h0b,
      MMD_R_SHR_A = 5'h0c, MMD_R_SHR_B = 5'h0d, MMD_R_SHR_C = 5'h0e,
      MMD_R_SHR_D = 5'h0f, MMD_R_ACCROM = 5'h10, MMD_R_OTP = 5'h11,
      MMD_R_PWD = 5'h12, MMD_R_FLASH = 5'h13, MMD_R_SROM = 5'h14,
      MMD_R_BROM = 5'h15, MMD_R_BOOTVEC = 5'h16
   } mmd_region_t;

   // one bus request
   typedef struct packed {
      logic valid;
      logic write;
      logic data_space;
      logic wide;
      logic [AW-1:0] addr;
      logic [DW-1:0] wdata;
   } mmd_req_t;

   // programmable wait states
   typedef struct packed {
      logic [4:0] otp_wait;
      logic [4:0] page_wait;
      logic [4:0] rand_wait;
   } mmd_wait_cfg_t;
endpackage

// file: rtl/mmd_region_decode.sv
// Purpose: combinational address to region lookup
// Assumes: word addresses on the unified map
// Notes: map steering bits qualify vector windows
`timescale 1ns/1ps
module mmd_region_decode
   import mmd_pkg::*;
(
   // address in
   input wire logic [mmd_pkg::AW-1:0] addr,
   input wire logic data_space,
   // map steering
   input wire logic vector_map_select,
   input wire logic expander_vector_enable,
   // result
   output mmd_region_t region
);
   // in-range check used for every window except the open-ended boot vector and boot rom tops
   function automatic logic in_win(input logic [21:0] a,
                                   input logic [21:0] lo,
                                   input logic [21:0] hi);
      in_win = (a >= lo) && (a < hi);
   endfunction

   // priority chain, narrow windows before wide frames
   always_comb begin
      region = MMD_R_NONE;
      if (in_win(addr, LOWVEC_LO, LOWVEC_HI) && !vector_map_select) begin
         region = MMD_R_LOWVEC; // [RL1]
      end else if (in_win(addr, LOWRAM_A_LO, LOWRAM_B_LO)) begin
         region = MMD_R_RAM_A; // [RL4]
      end else if (in_win(addr, LOWRAM_B_LO, LOWRAM_HI)) begin
         region = MMD_R_RAM_B; // [RL4]
      end else if (in_win(addr, EXPVEC_LO, EXPVEC_HI)) begin
         if (vector_map_select && expander_vector_enable && data_space) begin
            region = MMD_R_EXPVEC; // [RL2]
         end
      end else if (in_win(addr, TIMER_LO, TIMER_HI) && data_space) begin
         region = MMD_R_TIMER; // [RL22]
      end else if (in_win(addr, ACC2CPU_LO, CPU2ACC_LO) && data_space) begin
         region = MMD_R_A2C; // [RL7]
      end else if (in_win(addr, CPU2ACC_LO, CPU2ACC_HI) && data_space) begin
         region = MMD_R_C2A; // [RL8]
      end else if (in_win(addr, PF0_LO, PF0_HI) && data_space) begin
         region = MMD_R_PF0; // [RL23]
      end else if (in_win(addr, PF1A_LO, PF3_LO) && data_space) begin
         region = MMD_R_PF1; // [RL23]
      end else if (in_win(addr, PF3_LO, PF1B_LO) && data_space) begin
         region = MMD_R_PF3;
      end else if (in_win(addr, PF1B_LO, PF2_LO) && data_space) begin
         region = MMD_R_PF1;
      end else if (in_win(addr, PF2_LO, PF2_HI) && data_space) begin
         region = MMD_R_PF2;
      end else if (in_win(addr, SHR_A_LO, SHR_B_LO)) begin
         region = MMD_R_SHR_A; // [RL5]
      end else if (in_win(addr, SHR_B_LO, SHR_C_LO)) begin
         region = MMD_R_SHR_B;
      end else if (in_win(addr, SHR_C_LO, SHR_D_LO)) begin
         region = MMD_R_SHR_C;
      end else if (in_win(addr, SHR_D_LO, SHR_HI)) begin
         region = MMD_R_SHR_D;
      end else if (in_win(addr, ACCROM_LO, ACCROM_HI)) begin
         region = MMD_R_ACCROM;
      end else if (in_win(addr, PWD_LO, PWD_HI)) begin
         region = MMD_R_PWD; // [RL17]
      end else if (in_win(addr, CAL_LO, OTP_HI)) begin
         region = MMD_R_OTP; // [RL15]
      end else if (in_win(addr, FLASH_LO, FLASH_HI)) begin
         region = MMD_R_FLASH; // [RL6]
      end else if (in_win(addr, SROM_LO, SROM_HI)) begin
         region = MMD_R_SROM;
      end else if (addr >= BOOTVEC_LO) begin
         if (vector_map_select) begin
            region = MMD_R_BOOTVEC; // [RL3]
         end else begin
            region = MMD_R_BROM;
         end
      end else if (addr >= BROM_LO) begin
         region = MMD_R_BROM;
      end
   end
endmodule

// file: rtl/mmd_wait_counter.sv
// Purpose: counts wait states for one access
// Assumes: load and count enable come from the access controller
// Notes: zero is high for as long as the count stays at zero
`timescale 1ns/1ps
module mmd_wait_counter
   import mmd_pkg::*;
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic resetn,
   // control
   input wire logic load,
   input wire logic [4:0] load_val,
   input wire logic hold,
   // status
   output logic zero
);
   logic [4:0] cnt_q;
   logic [4:0] cnt_d;

   // next count: load, hold while ready is withheld, else step down
   always_comb begin
      cnt_d = cnt_q;
      if (load) begin
         cnt_d = load_val;
      end else if (!hold && cnt_q != 5'h00) begin
         cnt_d = cnt_q - 5'h01;
      end
   end

   // count register
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         cnt_q <= 5'h00;
      end else begin
         cnt_q <= cnt_d;
      end
   end

   assign zero = (cnt_q == 5'h00);
endmodule

// file: rtl/mmd_decoder.sv
// Purpose: steers cpu and accelerator accesses on the unified memory map
// Assumes: single clock, one outstanding access per master
// Notes: the cpu wins when both masters request in the same cycle
`timescale 1ns/1ps

// What this block does
// RL1 - low vector ram only when map select 0
// RL2 - expander vectors need select and enable set
// RL3 - boot vectors at top only when select 1
// RL4 - two 1K low rams, zero wait
// RL5 - four shared rams from 0x8000, zero wait
// RL6 - ten-sector flash with per-sector zone
// RL7 - cpu writes to accelerator-to-cpu ram ignored
// RL8 - accelerator writes to cpu-to-accelerator ram ignored
// RL9 - protected frames keep write-then-read order
// RL10 - order protection programmable, on after reset
// RL11 - frame 1 writes 0 wait, reads 2, ready stretches
// RL12 - back-to-back frame 1 writes stall one cycle
// RL13 - frame 2 fixed timing, no stretching
// RL14 - frame 3 timing, stretched by ready
// RL15 - otp waits programmable, never below one
// RL16 - flash paged min 0, random min 1
// RL17 - password locations fixed sixteen waits
// RL18 - protected writes need allow, blocked after disallow
// RL19 - frame 0 takes 16 and 32-bit accesses
// RL20 - frame 1 on 32-bit peripheral bus
// RL21 - frame 2 on 16-bit peripheral bus
// RL22 - timer block decoded, never write-protected
// RL23 - peripheral frames respond to data space only
// RL24 - reserved regions discard writes, read zero
module mmd_decoder
   import mmd_pkg::*;
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic resetn,
   // cpu request and answer
   input wire mmd_pkg::mmd_req_t cpu_req,
   input wire logic cpu_paged,
   input wire logic cpu_prot_range,
   output logic cpu_ready,
   output logic [mmd_pkg::DW-1:0] cpu_rdata,
   // accelerator request and answer
   input wire mmd_pkg::mmd_req_t acc_req,
   output logic acc_ready,
   // map and protection control
   input wire logic vector_map_select,
   input wire logic expander_vector_enable,
   input wire logic protected_write_allow,
   input wire logic protected_write_disallow,
   input wire logic order_prot_write,
   input wire logic order_prot_val,
   input wire mmd_pkg::mmd_wait_cfg_t wait_cfg,
   input wire logic [mmd_pkg::FLASH_SECTORS-1:0] sector_zone,
   output logic write_allowed,
   output logic order_prot_en,
   // target side
   output mmd_pkg::mmd_region_t tgt_region,
   output logic tgt_sel,
   output logic tgt_we,
   output logic tgt_wide,
   output logic tgt_zone,
   output logic [mmd_pkg::AW-1:0] tgt_addr,
   output logic [mmd_pkg::DW-1:0] tgt_wdata,
   input wire logic [mmd_pkg::DW-1:0] tgt_rdata,
   input wire logic periph_ready
);
   // ----------------------------------------------------------------
   // arbitration and decode
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      MMD_IDLE = 2'b00, MMD_WAIT = 2'b01, MMD_DONE = 2'b10
   } mmd_state_t;

   mmd_state_t st_q, st_d;
   mmd_req_t cur_q, cur_d;
   logic own_acc_q, own_acc_d;
   mmd_region_t reg_q, reg_d;
   logic allow_q, allow_d;
   logic oprot_q, oprot_d;
   logic last_pf1w_q, last_pf1w_d;
   logic last_pw_q, last_pw_d;
   logic [AW-1:0] last_addr_q, last_addr_d;
   logic [DW-1:0] rdata_q, rdata_d;
   mmd_req_t pick;
   logic pick_acc;
   mmd_region_t pick_region;
   logic wc_load, wc_zero, wc_hold;
   logic [4:0] wc_val;
   logic keep_write;
   logic [3:0] sec_idx;
   logic [15:0] fl_off;
   logic [3:0] fl_k;

   // cpu first, accelerator otherwise
   always_comb begin
      pick_acc = !cpu_req.valid && acc_req.valid;
      pick = pick_acc ? acc_req : cpu_req;
   end

   mmd_region_decode u_dec (
      .addr(pick.addr),
      .data_space(pick.data_space),
      .vector_map_select(vector_map_select),
      .expander_vector_enable(expander_vector_enable),
      .region(pick_region)
   );

   // is a frame region protected for ordering
   function automatic logic is_pframe(input mmd_region_t r);
      is_pframe = (r == MMD_R_PF1) || (r == MMD_R_PF2) || (r == MMD_R_PF3);
   endfunction

   // wait count per region for the picked access
   function automatic logic [4:0] clamp_min(input logic [4:0] v,
                                            input logic [4:0] m);
      clamp_min = (v < m) ? m : v;
   endfunction

   always_comb begin
      wc_val = 5'h00;
      case (pick_region)
         MMD_R_PF1: begin
            if (pick.write) begin
               wc_val = (last_pf1w_q) ? PF1_WW_STALL : 5'h00; // [RL12]
            end else begin
               wc_val = PF_READ_WAIT; // [RL11]
            end
         end
         MMD_R_PF2, MMD_R_PF3: begin
            wc_val = pick.write ? 5'h00 : PF_READ_WAIT; // [RL13] [RL14]
         end
         MMD_R_OTP: wc_val = clamp_min(wait_cfg.otp_wait, OTP_MIN_WAIT); // [RL15]
         MMD_R_PWD: wc_val = PWD_WAIT; // [RL17]
         MMD_R_FLASH: begin
            if (cpu_paged && !pick_acc) begin
               wc_val = wait_cfg.page_wait; // [RL16]
            end else begin
               wc_val = clamp_min(clamp_min(wait_cfg.rand_wait,
                                  RAND_MIN_WAIT), wait_cfg.page_wait); // [RL16]
            end
         end
         default: wc_val = 5'h00; // [RL4] [RL5] [RL19]
      endcase
      // write then read to another address in a protected frame
      if (oprot_q && last_pw_q && !pick.write && is_pframe(pick_region)
          && pick.addr != last_addr_q) begin
         wc_val = wc_val + PF_ORDER_WAIT; // [RL9]
      end
   end

   // ready stretching only in frames 1 and 3
   assign wc_hold = (st_q == MMD_WAIT) && !periph_ready &&
                    (reg_q == MMD_R_PF1 || reg_q == MMD_R_PF3); // [RL11] [RL14]
   assign wc_load = (st_q == MMD_IDLE) && pick.valid;

   mmd_wait_counter u_wait (
      .ref_clk(ref_clk),
      .resetn(resetn),
      .load(wc_load),
      .load_val(wc_val),
      .hold(wc_hold),
      .zero(wc_zero)
   );

   // ----------------------------------------------------------------
   // write filtering
   // ----------------------------------------------------------------
   always_comb begin
      keep_write = cur_q.write;
      if (reg_q == MMD_R_A2C && !own_acc_q) begin
         keep_write = 1'b0; // [RL7]
      end else if (reg_q == MMD_R_C2A && own_acc_q) begin
         keep_write = 1'b0; // [RL8]
      end else if (cpu_prot_range && !allow_q && !own_acc_q &&
                   reg_q != MMD_R_TIMER) begin
         keep_write = 1'b0; // [RL18] [RL22]
      end
   end

   // ----------------------------------------------------------------
   // state, allow latch, ordering history
   // ----------------------------------------------------------------
   always_comb begin
      st_d = st_q;
      cur_d = cur_q;
      own_acc_d = own_acc_q;
      reg_d = reg_q;
      rdata_d = rdata_q;
      last_pf1w_d = last_pf1w_q;
      last_pw_d = last_pw_q;
      last_addr_d = last_addr_q;
      allow_d = allow_q;
      oprot_d = order_prot_write ? order_prot_val : oprot_q; // [RL10]
      if (protected_write_disallow) begin
         allow_d = 1'b0; // [RL18]
      end else if (protected_write_allow) begin
         allow_d = 1'b1; // [RL18]
      end
      case (st_q)
         MMD_IDLE: begin
            if (pick.valid) begin
               st_d = MMD_WAIT;
               cur_d = pick;
               own_acc_d = pick_acc;
               reg_d = pick_region;
            end else begin
               last_pf1w_d = 1'b0;
               last_pw_d = 1'b0;
            end
         end
         MMD_WAIT: begin
            if (wc_zero && !wc_hold) begin
               st_d = MMD_DONE;
               // reserved space reads zero
               rdata_d = (reg_q == MMD_R_NONE) ? '0 : tgt_rdata; // [RL24]
               last_pf1w_d = cur_q.write && reg_q == MMD_R_PF1;
               last_pw_d = cur_q.write && is_pframe(reg_q);
               last_addr_d = cur_q.addr;
            end
         end
         MMD_DONE: st_d = MMD_IDLE;
         default: st_d = MMD_IDLE;
      endcase
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         st_q <= MMD_IDLE;
         cur_q <= '0;
         own_acc_q <= 1'b0;
         reg_q <= MMD_R_NONE;
         rdata_q <= '0;
         last_pf1w_q <= 1'b0;
         last_pw_q <= 1'b0;
         last_addr_q <= '0;
         allow_q <= 1'b0;
         oprot_q <= PROT_RESET; // [RL10]
      end else begin
         st_q <= st_d;
         cur_q <= cur_d;
         own_acc_q <= own_acc_d;
         reg_q <= reg_d;
         rdata_q <= rdata_d;
         last_pf1w_q <= last_pf1w_d;
         last_pw_q <= last_pw_d;
         last_addr_q <= last_addr_d;
         allow_q <= allow_d;
         oprot_q <= oprot_d;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   // sector from the 4K step inside the array: 4K, 4K, six 8K, 4K, 4K
   assign fl_off = 16'(cur_q.addr - FLASH_LO);
   assign fl_k = fl_off[15:12];
   assign sec_idx = (fl_k < 4'h2) ? fl_k :
                    (fl_k < 4'he) ? ((fl_k - 4'h2) >> 1) + 4'h2 :
                    fl_k - 4'h6;
   assign tgt_zone = (reg_q == MMD_R_FLASH) && sector_zone[sec_idx]; // [RL6]
   assign tgt_region = reg_q;
   assign tgt_sel = (st_q == MMD_WAIT) && reg_q != MMD_R_NONE; // [RL24]
   assign tgt_we = tgt_sel && keep_write;
   // frame 2 is 16 bits wide, frame 1 always 32
   assign tgt_wide = (reg_q == MMD_R_PF2) ? 1'b0 :
                     (reg_q == MMD_R_PF1) ? 1'b1 : cur_q.wide; // [RL20] [RL21]
   assign tgt_addr = cur_q.addr;
   assign tgt_wdata = (reg_q == MMD_R_PF2) ? {16'h0000, cur_q.wdata[15:0]}
                                           : cur_q.wdata;
   assign cpu_ready = (st_q == MMD_DONE) && !own_acc_q;
   assign acc_ready = (st_q == MMD_DONE) && own_acc_q;
   assign cpu_rdata = rdata_q;
   assign write_allowed = allow_q;
   assign order_prot_en = oprot_q;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!resetn);

   a_pf2_read_wait: assert property ( // [RL13]
      wc_load && pick_region == MMD_R_PF2 && !pick.write && !last_pw_q
      |=> (st_q == MMD_WAIT) [*3] ##1 st_q == MMD_DONE)
      else $error("frame 2 read wait wrong");
   a_pwd_sixteen: assert property ( // [RL17]
      wc_load && pick_region == MMD_R_PWD
      |=> (st_q == MMD_WAIT) [*8] ##9 st_q == MMD_WAIT
      ##1 st_q == MMD_DONE)
      else $error("password wait not sixteen");
   a_a2c_no_write: assert property ( // [RL7]
      tgt_sel && reg_q == MMD_R_A2C && !own_acc_q |-> !tgt_we)
      else $error("cpu write reached acc-to-cpu ram");
   a_c2a_no_write: assert property ( // [RL8]
      tgt_sel && reg_q == MMD_R_C2A && own_acc_q |-> !tgt_we)
      else $error("acc write reached cpu-to-acc ram");
   a_prot_blocked: assert property ( // [RL18]
      tgt_sel && cpu_prot_range && !allow_q && !own_acc_q &&
      reg_q != MMD_R_TIMER |-> !tgt_we)
      else $error("protected write passed");
   a_lowvec_gate: assert property ( // [RL1]
      tgt_sel && reg_q == MMD_R_LOWVEC |-> !$past(vector_map_select, 1)
      || $past(st_q) != MMD_IDLE)
      else $error("low vector with select set");
   a_pframe_data: assert property ( // [RL23]
      wc_load && !pick.data_space |=> !is_pframe(reg_q))
      else $error("frame answered program fetch");
   a_reserved_zero: assert property ( // [RL24]
      st_q == MMD_DONE && reg_q == MMD_R_NONE |-> rdata_q == '0)
      else $error("reserved read not zero");
   a_oprot_reset: assert property ( // [RL10]
      $rose(resetn) |-> order_prot_en)
      else $error("order protection off after reset");
   a_otp_min: assert property ( // [RL15]
      wc_load && pick_region == MMD_R_OTP |=> st_q == MMD_WAIT [*2])
      else $error("otp under one wait");
   c_pf1_ready: cover property (wc_hold ##1 !wc_hold);
   c_pf1_ww: cover property (wc_load && pick_region == MMD_R_PF1
                             && pick.write && last_pf1w_q);
   c_order: cover property (wc_load && oprot_q && last_pw_q && !pick.write);
   c_flash: cover property (tgt_sel && reg_q == MMD_R_FLASH);
endmodule

// file: bench/mmd_tgt_model.sv
// Purpose: target side stand-in for the decoder
// Assumes: one access at a time
// Notes: ready is withheld for the first stall_n select cycles
`timescale 1ns/1ps
module mmd_tgt_model (
   // clock
   input wire logic ref_clk,
   // decoder target side
   input wire logic tgt_sel,
   input wire logic [mmd_pkg::AW-1:0] tgt_addr,
   output logic [mmd_pkg::DW-1:0] tgt_rdata,
   output logic periph_ready,
   // stall length from the bench
   input wire logic [3:0] stall_n
);
   import mmd_pkg::*;
   logic [3:0] cnt_q;
   // count cycles of the current select
   always_ff @(posedge ref_clk) begin
      if (!tgt_sel) cnt_q <= 4'h0;
      else if (cnt_q != 4'hf) cnt_q <= cnt_q + 4'h1;
   end
   assign periph_ready = !(tgt_sel && cnt_q < stall_n);
   // unselected data is the inverse pattern, never a stale match
   assign tgt_rdata = tgt_sel ? {10'h000, tgt_addr} : ~{10'h000, tgt_addr};
endmodule

// file: bench/memory_map_decoder_tb.sv
// Purpose: self-checking bench for the memory map decoder
// Assumes: the target model answers behind the decoder
// Notes: latencies are judged against a zero-wait ram access
`timescale 1ns/1ps
module memory_map_decoder_tb;
   import mmd_pkg::*;
   logic ref_clk, resetn, pgd, prt, vms, eve, pwa, pwd, opw, opv;
   logic cr, ar, wa, ope, sel, we, wi, ws, ss, wo, w16, pr, zo, zn;
   mmd_req_t cq, aq;
   mmd_wait_cfg_t wc;
   mmd_region_t tr, rg;
   logic [31:0] rdat, trd, wd, tw;
   logic [9:0] szn;
   logic [21:0] ta;
   logic [3:0] stl;
   int miscompares = 0, check_count = 0, cyc = 0, base = 0, l;
   mmd_decoder dut_u (.ref_clk(ref_clk), .resetn(resetn), .cpu_req(cq),
      .cpu_paged(pgd), .cpu_prot_range(prt), .cpu_ready(cr),
      .cpu_rdata(rdat), .acc_req(aq), .acc_ready(ar),
      .vector_map_select(vms), .expander_vector_enable(eve),
      .protected_write_allow(pwa), .protected_write_disallow(pwd),
      .order_prot_write(opw), .order_prot_val(opv), .wait_cfg(wc),
      .sector_zone(szn), .write_allowed(wa), .order_prot_en(ope),
      .tgt_region(tr), .tgt_sel(sel), .tgt_we(we), .tgt_wide(wi),
      .tgt_zone(zn), .tgt_addr(ta), .tgt_wdata(tw), .tgt_rdata(trd),
      .periph_ready(pr));
   mmd_tgt_model tgt_u (.ref_clk(ref_clk), .tgt_sel(sel), .tgt_addr(ta),
      .tgt_rdata(trd), .periph_ready(pr), .stall_n(stl));
   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      check_count++;
      if (g !== e) begin
         miscompares++;
         $display("mismatch at %0t: got %h want %h", $time, g, e);
      end
   endtask
   task automatic end_sim;
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   // one access, held until its ready is seen; a lost ready hits the guard
   task automatic xf(input logic m, w, ds, input logic [21:0] a);
      if (m) aq = {1'b1, w, ds, w16, a, 32'h5a5aa5a5};
      else cq = {1'b1, w, ds, w16, a, 32'h5a5aa5a5};
      l = 0;
      ws = 1'b0;
      ss = 1'b0;
      rg = MMD_R_NONE;
      do begin
         @(negedge ref_clk);
         l++;
         ws |= we & sel;
         ss |= sel;
         if (sel) rg = tr;
         if (sel) wo = wi;
         if (sel) zo = zn;
         if (sel) wd = tw;
      end while ((m ? ar : cr) !== 1'b1);
      @(posedge ref_clk);
      #1;
   endtask
   task automatic tx(input logic w, input logic [21:0] a, input int n);
      xf(1'b0, w, 1'b1, a);
      chk(l - base, n);
   endtask
   task automatic idl;
      cq.valid = 1'b0;
      aq.valid = 1'b0;
      @(posedge ref_clk);
      #1;
   endtask
   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   task automatic t_map;
      xf(1'b0, 1'b0, 1'b1, 22'h000400);
      base = l;
      chk(rdat, 32'h00000400);
      chk(rg, MMD_R_RAM_B);
      tx(1'b0, 22'h000000, 0);
      chk(rg, MMD_R_LOWVEC);
      tx(1'b0, 22'h009000, 0);
      chk(rg, MMD_R_SHR_D);
      vms = 1'b1;
      tx(1'b0, 22'h000d00, 0);
      chk(rg, MMD_R_NONE);
      eve = 1'b1;
      tx(1'b0, 22'h000d00, 0);
      chk(rg, MMD_R_EXPVEC);
      tx(1'b0, 22'h3fffc0, 0);
      chk(rg, MMD_R_BOOTVEC);
      tx(1'b0, 22'h000000, 0);
      chk(rg, MMD_R_RAM_A);
      xf(1'b0, 1'b0, 1'b1, 22'h3e8000);
      chk(rg, MMD_R_FLASH);
      chk(zo, 1'b1);
      idl();
   endtask
   task automatic t_wait;
      stl = 4'h3;
      tx(1'b0, 22'h007000, 2);
      chk(wo, 1'b0);
      tx(1'b0, 22'h006000, 5);
      chk(wo, 1'b1);
      stl = 4'h2;
      tx(1'b0, 22'h006400, 4);
      stl = 4'h0;
      idl();
      tx(1'b1, 22'h006000, 0);
      tx(1'b1, 22'h006002, 1);
      idl();
      tx(1'b1, 22'h006004, 0);
      tx(1'b0, 22'h3d7e00, 1);
      tx(1'b0, 22'h3d7800, 16);
      tx(1'b0, 22'h3e9000, 1);
      chk(zo, 1'b0);
      pgd = 1'b1;
      tx(1'b0, 22'h3e9002, 0);
      pgd = 1'b0;
      w16 = 1'b0;
      tx(1'b0, 22'h000880, 0);
      chk(wo, 1'b0);
      w16 = 1'b1;
      idl();
   endtask
   task automatic t_order;
      chk(ope, 1'b1);
      tx(1'b1, 22'h006400, 0);
      tx(1'b0, 22'h006410, 3);
      idl();
      opw = 1'b1;
      @(posedge ref_clk);
      #1;
      opw = 1'b0;
      chk(ope, 1'b0);
      tx(1'b1, 22'h006400, 0);
      tx(1'b0, 22'h006410, 2);
      idl();
   endtask
   task automatic t_filt;
      xf(1'b0, 1'b1, 1'b1, 22'h001480);
      chk(ws, 1'b0);
      xf(1'b0, 1'b1, 1'b1, 22'h001500);
      chk(ws, 1'b1);
      idl();
      xf(1'b1, 1'b1, 1'b1, 22'h001500);
      chk(ws, 1'b0);
      idl();
      prt = 1'b1;
      xf(1'b0, 1'b1, 1'b1, 22'h007010);
      chk(ws, 1'b0);
      xf(1'b0, 1'b1, 1'b1, 22'h000c00);
      chk(ws, 1'b1);
      idl();
      pwa = 1'b1;
      @(posedge ref_clk);
      #1;
      pwa = 1'b0;
      chk(wa, 1'b1);
      xf(1'b0, 1'b1, 1'b1, 22'h007010);
      chk(ws, 1'b1);
      chk(wd, 32'h0000a5a5);
      idl();
      pwd = 1'b1;
      @(posedge ref_clk);
      #1;
      pwd = 1'b0;
      xf(1'b0, 1'b1, 1'b1, 22'h007010);
      chk(ws, 1'b0);
      prt = 1'b0;
      xf(1'b0, 1'b0, 1'b1, 22'h002000);
      chk(ss, 1'b0);
      chk(rdat, 32'h00000000);
      xf(1'b0, 1'b0, 1'b0, 22'h006000);
      chk(ss, 1'b0);
      chk(rdat, 32'h00000000);
      idl();
   endtask
   initial begin
      ref_clk = 1'b0;
      forever #20 ref_clk = ~ref_clk;
   end
   // hang guard
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 5000) begin
         $display("mismatch at %0t: ready never came", $time);
         miscompares++;
         end_sim();
      end
   end
   initial begin
      {resetn, pgd, prt, vms, eve, pwa, pwd, opw, opv, w16} = 10'h001;
      cq = '0;
      aq = '0;
      wc = '0;
      // lowest and highest sectors in zone 1, the rest in zone 0
      szn = 10'h201;
      stl = 4'h0;
      repeat (6) @(posedge ref_clk);
      #1;
      resetn = 1'b1;
      chk(wa, 1'b0);
      t_map();
      t_wait();
      t_order();
      t_filt();
      end_sim();
   end
endmodule
